// ==== rtl/sis_status_core.sv ====
// Status indicator, service access override, fault handling and
// clear-to-send timing, with an AHB-Lite register slave.
// Assumes all pins synchronous to MCLK (100 MHz) and a single master.
//
// Function
// RULE_01: Service low forces 38400 8N1 framing
// RULE_02: Service never alters stored config or mode
// RULE_03: Service high restores stored port framing
// RULE_04: Service low forces serial-link commands on
// RULE_05: Searching: indicator held high
// RULE_06: Receiving frame: indicator held low
// RULE_07: Light sleep: indicator held low
// RULE_08: Transmitting: toggle at transmission interval
// RULE_09: Tool connected: toggle every 1 s
// RULE_10: Escape-enabled commands: toggle every 500 ms
// RULE_11: Fault: toggle 250 ms, code readable
// RULE_12: Clear-to-send output is active low
// RULE_13: Host request-to-send input active low, pulled up
// RULE_14: Enable pin low resets volatile state
// RULE_15: Fault reboots after 5 s, radio inhibited
// RULE_16: Clear-to-send asserted 100-500 ms after enable
// RULE_17: Fault beats tool/escape beats radio activity
// RULE_18: Intervals are counted between indicator changes
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sis_params.svh"
module sis_status_core #(
   parameter logic [31:0] P_TOOL_CYC = 32'(`SIS_TOOL_MS * `SIS_CYC_PER_MS),
   parameter logic [31:0] P_ESC_CYC = 32'(`SIS_ESC_MS * `SIS_CYC_PER_MS),
   parameter logic [31:0] P_FAULT_CYC = 32'(`SIS_FAULT_MS * `SIS_CYC_PER_MS),
   parameter logic [31:0] P_REBOOT_CYC = 32'(`SIS_REBOOT_MS * `SIS_CYC_PER_MS),
   parameter logic [31:0] P_CTS_CYC = 32'(`SIS_CTS_MS * `SIS_CYC_PER_MS)
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire sis_pkg::sis_htrans_t HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Host pins
   input wire logic MODULE_ENABLE_PIN,
   input wire logic SERVICE_ACCESS_N,
   input wire logic REQUEST_TO_SEND_IN_N,
   output logic CLEAR_TO_SEND_OUT_N,
   output logic STAT,
   // Radio and firmware state
   input wire logic RX_FRAME_ACTIVE,
   input wire logic TX_ACTIVE,
   input wire logic LIGHT_SLEEP_STATE,
   input wire logic TOOL_LINK_ACTIVE,
   input wire logic ESC_SEQ_ACTIVE,
   input wire logic FAULT_DETECT,
   input wire logic [7:0] FAULT_CODE_IN,
   // Effective port setup and control
   output logic [16:0] PRIMARY_SERIAL_PORT_BAUD,
   output logic PRIMARY_SERIAL_PORT_DATA8,
   output logic [1:0] PRIMARY_SERIAL_PORT_PARITY,
   output logic PRIMARY_SERIAL_PORT_STOP2,
   output logic SERIAL_LINK_COMMAND_SET_EN,
   output logic RADIO_INHIBIT,
   output logic REBOOT_REQ,
   output logic IRQ
);
   import sis_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic clr;
   logic [31:0] cfg_reg, cfg_next, txivl_reg, txivl_next;
   logic wr_pend_reg, wr_pend_next;
   logic [7:0] wr_addr_reg, wr_addr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic hready_reg;
   logic addr_ph;
   logic clr_we, en_we;
   logic [3:0] irq_st, irq_en, irq_evt;
   logic fault_reg, fault_next;
   logic [7:0] fcode_reg, fcode_next;
   logic cts_rdy_reg, cts_rdy_next;
   logic svc_prev_reg;
   logic reboot_tick, cts_tick, blink_tick;
   logic reboot_reg;
   sis_mode_e mode, mode_reg;
   logic blinking;
   logic [31:0] blink_lim;
   logic stat_reg, stat_next;
   logic [16:0] baud_next;
   logic data8_next, stop2_next, sl_next;
   logic [1:0] par_next;
   logic [16:0] baud_reg;
   logic data8_reg, stop2_reg, sl_reg;
   logic [1:0] par_reg;

   // Enable pin low clears volatile state, except the interrupt status and enable bits (reset by RST only)
   assign clr = RST || !MODULE_ENABLE_PIN; // RULE_14

   // ----------------------------------------------------------------
   // AHB-Lite register slave
   // ----------------------------------------------------------------
   assign addr_ph = HSEL && HREADY && HTRANS[1];

   // Address phase capture, read data and data-phase writes
   always_comb begin
      wr_pend_next = addr_ph && HWRITE;
      wr_addr_next = addr_ph ? HADDR[7:0] : wr_addr_reg;
      rdata_next = 32'h0;
      if (addr_ph && !HWRITE) begin
         case (HADDR[7:0])
            `SIS_OFS_CFG: rdata_next = cfg_reg;
            `SIS_OFS_TXIVL: rdata_next = txivl_reg;
            `SIS_OFS_STATUS: rdata_next = {22'h0, REQUEST_TO_SEND_IN_N, SERVICE_ACCESS_N,
               fault_reg, CLEAR_TO_SEND_OUT_N, STAT, sl_reg, mode_reg, 1'b0};
            `SIS_OFS_FCODE: rdata_next = {24'h0, fcode_reg}; // RULE_11
            `SIS_OFS_INTST: rdata_next = {28'h0, irq_st};
            `SIS_OFS_INTEN: rdata_next = {28'h0, irq_en};
            default: rdata_next = 32'h0;
         endcase
      end
      // Only the bus writes stored setup; service never touches it
      cfg_next = (wr_pend_reg && wr_addr_reg == `SIS_OFS_CFG) ? HWDATA : cfg_reg; // RULE_02
      txivl_next = (wr_pend_reg && wr_addr_reg == `SIS_OFS_TXIVL) ?
         ((HWDATA == 32'h0) ? 32'h1 : HWDATA) : txivl_reg;
   end

   assign clr_we = wr_pend_reg && (wr_addr_reg == `SIS_OFS_INTCLR);
   assign en_we = wr_pend_reg && (wr_addr_reg == `SIS_OFS_INTEN);

   // Bus registers; stored setup survives the enable pin
   always_ff @(posedge MCLK) begin
      if (RST) begin
         cfg_reg <= `SIS_CFG_RST;
         txivl_reg <= `SIS_TXIVL_RST;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg <= 32'h0;
         hready_reg <= 1'b1;
      end else begin
         cfg_reg <= cfg_next;
         txivl_reg <= txivl_next;
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg <= rdata_next;
         hready_reg <= 1'b1;
      end
   end

   assign HRDATA = rdata_reg;
   assign HREADYOUT = hready_reg;
   assign HRESP = 1'b0;

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   always_comb begin
      irq_evt = 4'h0;
      irq_evt[`SIS_IRQ_FAULT] = FAULT_DETECT && !fault_reg && MODULE_ENABLE_PIN;
      irq_evt[`SIS_IRQ_REBOOT] = reboot_tick;
      irq_evt[`SIS_IRQ_CTS] = cts_tick;
      irq_evt[`SIS_IRQ_SVC] = (svc_prev_reg != SERVICE_ACCESS_N);
   end

   sis_irq_bank u_irq (
      .clk(MCLK),
      .rst(RST),
      .evt(irq_evt),
      .clr_we(clr_we),
      .en_we(en_we),
      .wdata(HWDATA[3:0]),
      .status(irq_st),
      .enable(irq_en),
      .irq(IRQ)
   );

   // ----------------------------------------------------------------
   // Fault, reboot and clear-to-send
   // ----------------------------------------------------------------
   sis_tick_timer u_reboot (
      .clk(MCLK),
      .rst(clr),
      .run(fault_reg),
      .limit(P_REBOOT_CYC),
      .tick(reboot_tick)
   );

   sis_tick_timer u_cts (
      .clk(MCLK),
      .rst(clr),
      .run(!cts_rdy_reg && !fault_reg),
      .limit(P_CTS_CYC),
      .tick(cts_tick)
   );

   // Fault latches until the reboot; the reboot reruns the start delay
   always_comb begin
      fault_next = (fault_reg || FAULT_DETECT) && !reboot_tick; // RULE_15
      fcode_next = (FAULT_DETECT && !fault_reg) ? FAULT_CODE_IN : fcode_reg; // RULE_11
      cts_rdy_next = (cts_rdy_reg || cts_tick) && !reboot_tick && !fault_next; // RULE_16
   end

   // Volatile state, cleared by the enable pin
   always_ff @(posedge MCLK) begin
      if (clr) begin
         fault_reg <= 1'b0;
         fcode_reg <= 8'h00;
         cts_rdy_reg <= 1'b0;
         reboot_reg <= 1'b0;
         svc_prev_reg <= 1'b1;
      end else begin
         fault_reg <= fault_next;
         fcode_reg <= fcode_next;
         cts_rdy_reg <= cts_rdy_next;
         reboot_reg <= reboot_tick;
         svc_prev_reg <= SERVICE_ACCESS_N;
      end
   end

   assign CLEAR_TO_SEND_OUT_N = !cts_rdy_reg; // RULE_12
   assign RADIO_INHIBIT = fault_reg; // RULE_15
   assign REBOOT_REQ = reboot_reg;

   // ----------------------------------------------------------------
   // Status indicator
   // ----------------------------------------------------------------
   // Pick the indication by priority
   always_comb begin
      if (!MODULE_ENABLE_PIN) begin
         mode = SIS_OFF;
      end else if (fault_reg) begin
         mode = SIS_FAULT; // RULE_17
      end else if (TOOL_LINK_ACTIVE) begin
         mode = SIS_TOOL;
      end else if (ESC_SEQ_ACTIVE && !cfg_reg[`SIS_CFG_SLON]) begin
         mode = SIS_ESC;
      end else if (TX_ACTIVE) begin
         mode = SIS_TX;
      end else if (LIGHT_SLEEP_STATE) begin
         mode = SIS_SLEEP;
      end else if (RX_FRAME_ACTIVE) begin
         mode = SIS_RX;
      end else begin
         mode = SIS_SEARCH;
      end
   end

   // Interval per blinking indication
   always_comb begin
      blinking = 1'b1;
      case (mode)
         SIS_FAULT: blink_lim = P_FAULT_CYC; // RULE_11
         SIS_TOOL: blink_lim = P_TOOL_CYC; // RULE_09
         SIS_ESC: blink_lim = P_ESC_CYC; // RULE_10
         SIS_TX: blink_lim = txivl_reg; // RULE_08
         default: begin
            blink_lim = 32'h1;
            blinking = 1'b0;
         end
      endcase
   end

   // Timer restarts on any change of indication
   sis_tick_timer u_blink (
      .clk(MCLK),
      .rst(clr),
      .run(blinking && (mode == mode_reg)),
      .limit(blink_lim),
      .tick(blink_tick)
   );

   // Indicator level; blinking toggles only on the interval tick
   always_comb begin
      case (mode)
         SIS_SEARCH: stat_next = 1'b1; // RULE_05
         SIS_RX: stat_next = 1'b0; // RULE_06
         SIS_SLEEP: stat_next = 1'b0; // RULE_07
         SIS_OFF: stat_next = 1'b0;
         default: stat_next = (blink_tick && mode == mode_reg) ? !stat_reg : stat_reg; // RULE_18
      endcase
   end

   // ----------------------------------------------------------------
   // Service access override of the primary port
   // ----------------------------------------------------------------
   always_comb begin
      if (!SERVICE_ACCESS_N) begin
         baud_next = `SIS_SVC_BAUD; // RULE_01
         data8_next = 1'b1;
         par_next = 2'b00;
         stop2_next = 1'b0;
      end else begin
         baud_next = cfg_reg[16:0]; // RULE_03
         data8_next = cfg_reg[`SIS_CFG_DATA8];
         par_next = cfg_reg[`SIS_CFG_PAR_LO +: 2];
         stop2_next = cfg_reg[`SIS_CFG_STOP2];
      end
      sl_next = !SERVICE_ACCESS_N || cfg_reg[`SIS_CFG_SLON] || ESC_SEQ_ACTIVE; // RULE_04
   end

   // Indicator and port registers
   always_ff @(posedge MCLK) begin
      if (clr) begin
         mode_reg <= SIS_OFF;
         stat_reg <= 1'b0;
         baud_reg <= 17'h0;
         data8_reg <= 1'b0;
         par_reg <= 2'b00;
         stop2_reg <= 1'b0;
         sl_reg <= 1'b0;
      end else begin
         mode_reg <= mode;
         stat_reg <= stat_next;
         baud_reg <= baud_next;
         data8_reg <= data8_next;
         par_reg <= par_next;
         stop2_reg <= stop2_next;
         sl_reg <= sl_next;
      end
   end

   assign STAT = stat_reg;
   assign PRIMARY_SERIAL_PORT_BAUD = baud_reg;
   assign PRIMARY_SERIAL_PORT_DATA8 = data8_reg;
   assign PRIMARY_SERIAL_PORT_PARITY = par_reg;
   assign PRIMARY_SERIAL_PORT_STOP2 = stop2_reg;
   assign SERIAL_LINK_COMMAND_SET_EN = sl_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (clr);

   property p_svc_frame;
      !SERVICE_ACCESS_N ##1 !SERVICE_ACCESS_N |-> PRIMARY_SERIAL_PORT_BAUD == 17'h09600 &&
         PRIMARY_SERIAL_PORT_DATA8 && PRIMARY_SERIAL_PORT_PARITY == 2'b00 &&
         !PRIMARY_SERIAL_PORT_STOP2;
   endproperty
   a_svc_frame: assert property (p_svc_frame) else $error("service framing wrong"); // RULE_01

   property p_svc_cfg_kept;
      !SERVICE_ACCESS_N && !wr_pend_reg |=> $stable(cfg_reg);
   endproperty
   a_svc_cfg_kept: assert property (p_svc_cfg_kept) else $error("config changed"); // RULE_02

   property p_svc_restore;
      $rose(SERVICE_ACCESS_N) && !wr_pend_reg |=> PRIMARY_SERIAL_PORT_BAUD == cfg_reg[16:0];
   endproperty
   a_svc_restore: assert property (p_svc_restore) else $error("port not restored"); // RULE_03

   property p_svc_sl;
      !SERVICE_ACCESS_N |=> SERIAL_LINK_COMMAND_SET_EN;
   endproperty
   a_svc_sl: assert property (p_svc_sl) else $error("commands not forced on"); // RULE_04

   property p_search_high;
      mode == SIS_SEARCH && MODULE_ENABLE_PIN |=> STAT;
   endproperty
   a_search_high: assert property (p_search_high) else $error("search not high"); // RULE_05

   property p_rx_sleep_low;
      (mode == SIS_RX || mode == SIS_SLEEP) && MODULE_ENABLE_PIN |=> !STAT;
   endproperty
   a_rx_sleep_low: assert property (p_rx_sleep_low) else $error("indicator not low"); // RULE_06

   property p_fault_first;
      fault_reg && MODULE_ENABLE_PIN |-> mode == SIS_FAULT && blink_lim == P_FAULT_CYC;
   endproperty
   a_fault_first: assert property (p_fault_first) else $error("fault not first"); // RULE_17

   property p_tool_ivl;
      mode == SIS_TOOL |-> blink_lim == P_TOOL_CYC;
   endproperty
   a_tool_ivl: assert property (p_tool_ivl) else $error("tool interval wrong"); // RULE_09

   property p_toggle_on_tick;
      blinking && mode == mode_reg && !blink_tick ##1 mode == $past(mode) |-> $stable(STAT);
   endproperty
   a_toggle_on_tick: assert property (p_toggle_on_tick) else $error("stray toggle"); // RULE_18

   property p_fault_inhibit;
      $rose(fault_reg) |-> RADIO_INHIBIT && CLEAR_TO_SEND_OUT_N;
   endproperty
   a_fault_inhibit: assert property (p_fault_inhibit) else $error("radio not inhibited"); // RULE_15

   property p_cts_time;
      $fell(CLEAR_TO_SEND_OUT_N) |-> $past(cts_tick);
   endproperty
   a_cts_time: assert property (p_cts_time) else $error("early clear-to-send"); // RULE_16

   c_fault_blink: cover property (mode == SIS_FAULT && blink_tick);
   c_reboot: cover property (REBOOT_REQ);
   c_service: cover property (!SERVICE_ACCESS_N ##1 SERVICE_ACCESS_N);
   c_cts: cover property ($fell(CLEAR_TO_SEND_OUT_N));
endmodule

// ==== rtl/sis_params.svh ====
// Constants of the status indicator and service mode block.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef SIS_PARAMS_SVH
`define SIS_PARAMS_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SIS_CLK_HZ 100000000
`define SIS_CYC_PER_MS (`SIS_CLK_HZ / 1000)
`define SIS_TOOL_MS 1000
`define SIS_ESC_MS 500
`define SIS_FAULT_MS 250
`define SIS_REBOOT_MS 5000
`define SIS_CTS_MS 200
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SIS_OFS_CFG 8'h00
`define SIS_OFS_TXIVL 8'h04
`define SIS_OFS_STATUS 8'h08
`define SIS_OFS_FCODE 8'h0c
`define SIS_OFS_INTST 8'h10
`define SIS_OFS_INTCLR 8'h14
`define SIS_OFS_INTEN 8'h18
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SIS_CFG_DATA8 17
`define SIS_CFG_PAR_LO 18
`define SIS_CFG_STOP2 20
`define SIS_CFG_SLON 21
`define SIS_CFG_RST 32'h0023c200
`define SIS_TXIVL_RST 32'h00989680
`define SIS_SVC_BAUD 17'h09600
`define SIS_IRQ_W 4
`define SIS_IRQ_FAULT 0
`define SIS_IRQ_REBOOT 1
`define SIS_IRQ_CTS 2
`define SIS_IRQ_SVC 3
`endif

// ==== rtl/sis_pkg.sv ====
// Types of the status indicator and service mode block.
// Assumes nothing beyond the constants header.
package sis_pkg;
   typedef logic [1:0] sis_htrans_t;
   typedef enum logic [2:0] {
      SIS_SEARCH = 3'b000,
      SIS_RX = 3'b001,
      SIS_SLEEP = 3'b010,
      SIS_TX = 3'b011,
      SIS_ESC = 3'b100,
      SIS_TOOL = 3'b101,
      SIS_FAULT = 3'b110,
      SIS_OFF = 3'b111
   } sis_mode_e;
endpackage

// ==== rtl/sis_tick_timer.sv ====
// Interval timer: one-cycle tick every LIMIT cycles while running.
// Assumes limit >= 1; dropping run restarts the count from zero.
`timescale 1ns/1ps
module sis_tick_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic [31:0] limit,
   // Result
   output logic tick
);
   logic [31:0] cnt_reg, cnt_next;
   logic tick_reg, tick_next;

   // Count up to limit-1, then tick and wrap
   always_comb begin
      // At or past the end, so a limit lowered mid-count cannot strand it
      tick_next = run && (cnt_reg >= limit - 32'h1);
      cnt_next = (run && !tick_next) ? cnt_reg + 32'h1 : 32'h0;
   end

   // State registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 32'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule

// ==== rtl/sis_irq_bank.sv ====
// Sticky interrupt status with enable mask and one level output.
// Assumes one-cycle clear and enable write strobes from the bus slave.
`timescale 1ns/1ps
module sis_irq_bank (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Events and software access
   input wire logic [3:0] evt,
   input wire logic clr_we,
   input wire logic en_we,
   input wire logic [3:0] wdata,
   // State
   output logic [3:0] status,
   output logic [3:0] enable,
   output logic irq
);
   logic [3:0] st_reg, st_next, en_reg, en_next;
   logic irq_reg, irq_next;

   // Set wins over clear in the same cycle
   always_comb begin
      st_next = (st_reg & ~(clr_we ? wdata : 4'h0)) | evt;
      en_next = en_we ? wdata : en_reg;
      irq_next = |(st_next & en_next);
   end

   // State registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= 4'h0;
         en_reg <= 4'h0;
         irq_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         en_reg <= en_next;
         irq_reg <= irq_next;
      end
   end

   assign status = st_reg;
   assign enable = en_reg;
   assign irq = irq_reg;
endmodule

// ==== bench/sis_host_model.sv ====
// Terminal host model: drives the enable, service and request-to-send pins.
// Assumes bench commands arrive by non-blocking assignment on the clock edge.
`timescale 1ns/1ps
module sis_host_model (
   // Clock
   input wire logic clk,
   // Bench commands
   input wire logic ena_cmd,
   input wire logic svc_cmd,
   input wire logic rts_cmd,
   // Device pins
   input wire logic cts_n,
   output logic ena_pin,
   output logic service_n,
   output logic rts_n
);
   // Pins idle high except enable, which starts low
   initial begin
      ena_pin = 1'b0;
      service_n = 1'b1;
      rts_n = 1'b1;
   end
   // Pins change only just after an edge
   always @(posedge clk) begin
      ena_pin <= ena_cmd;
      service_n <= ~svc_cmd; // Released input floats back high
      rts_n <= ~(rts_cmd & ~cts_n);
   end
endmodule

// ==== bench/status_indicator_and_service_mode_tb.sv ====
// Self-checking bench for the status indicator and service mode core.
// Assumes shortened blink, reboot and clear-to-send counts.
`timescale 1ns/1ps
`include "sis_params.svh"
module status_indicator_and_service_mode_tb;
   import sis_pkg::*;
   typedef struct {logic [4:0] in; int per; logic lvl;} sis_row_s;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   sis_htrans_t htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic rx = 1'b0, tx = 1'b0, slp = 1'b0, tool = 1'b0, esc = 1'b0, fault = 1'b0;
   logic [7:0] fcode = 8'ha5;
   logic ena_cmd = 1'b1, svc_cmd = 1'b0, rts_cmd = 1'b0;
   wire ena, svc_n, rts_n, cts_n, stat, hready, hresp, inhibit, reboot, irq;
   wire d8, stop2, cmd_en;
   wire [31:0] hrdata;
   wire [16:0] baud;
   wire [1:0] par;
   int errors = 0;
   int tests_run = 0;
   int n, t0;
   int cyc = 0;
   logic [31:0] rd;
   // Static rows wait out the gap limit; blink rows give the toggle period
   sis_row_s rows [10] = '{'{5'b00000, 300, 1'b1}, '{5'b10000, 300, 1'b0},
      '{5'b00100, 300, 1'b0}, '{5'b10100, 300, 1'b0}, '{5'b01000, 16, 1'b0},
      '{5'b00010, 40, 1'b0}, '{5'b01010, 40, 1'b0}, '{5'b00001, 20, 1'b0},
      '{5'b00011, 40, 1'b0}, '{5'b01001, 20, 1'b0}};

   // -----------------------------------------------------------------
   // Design, host and clock
   // -----------------------------------------------------------------
   sis_status_core #(.P_TOOL_CYC(32'd40), .P_ESC_CYC(32'd20), .P_FAULT_CYC(32'd10),
      .P_REBOOT_CYC(32'd200), .P_CTS_CYC(32'd30)) sis_status_core_inst (
      .MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
      .MODULE_ENABLE_PIN(ena), .SERVICE_ACCESS_N(svc_n), .REQUEST_TO_SEND_IN_N(rts_n),
      .CLEAR_TO_SEND_OUT_N(cts_n), .STAT(stat), .RX_FRAME_ACTIVE(rx), .TX_ACTIVE(tx),
      .LIGHT_SLEEP_STATE(slp), .TOOL_LINK_ACTIVE(tool), .ESC_SEQ_ACTIVE(esc),
      .FAULT_DETECT(fault), .FAULT_CODE_IN(fcode), .PRIMARY_SERIAL_PORT_BAUD(baud),
      .PRIMARY_SERIAL_PORT_DATA8(d8), .PRIMARY_SERIAL_PORT_PARITY(par),
      .PRIMARY_SERIAL_PORT_STOP2(stop2), .SERIAL_LINK_COMMAND_SET_EN(cmd_en),
      .RADIO_INHIBIT(inhibit), .REBOOT_REQ(reboot), .IRQ(irq));
   sis_host_model sis_host_model_inst (.clk(mclk), .ena_cmd(ena_cmd), .svc_cmd(svc_cmd),
      .rts_cmd(rts_cmd), .cts_n(cts_n), .ena_pin(ena), .service_n(svc_n), .rts_n(rts_n));
   // Clock and free-running cycle count
   always #5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   // -----------------------------------------------------------------
   // Tasks
   // -----------------------------------------------------------------
   // Compare and count
   task chk(string name, logic [31:0] got, logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // One AHB-Lite single transfer; read data taken at the data-phase edge
   task xfer(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task ticks(int k);
      repeat (k) @(posedge mclk);
   endtask
   // Cycles until the indicator changes, capped at 300
   task stat_gap(output int k);
      logic s;
      s = stat;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (stat === s && k < 300);
   endtask
   // Cycles until clear-to-send goes active
   task cts_wait(output int k);
      k = 0;
      while (cts_n !== 1'b0 && k < 300) begin
         @(posedge mclk);
         k++;
      end
   endtask
   // Verdict and end of run
   task summarize;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Watchdog and tests
   // -----------------------------------------------------------------
   // Cuts a hang short well beyond the expected run
   initial begin
      #200000;
      errors++;
      summarize;
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      cts_wait(n);
      chk("cts_delay", n >= 30 && n <= 34, 1);
      xfer(0, `SIS_OFS_CFG, 0);
      chk("cfg_reset", rd, 32'h0023c200);
      xfer(0, `SIS_OFS_TXIVL, 0);
      chk("txivl_reset", rd, 32'h00989680);
      rts_cmd <= 1'b1;
      ticks(4);
      xfer(0, `SIS_OFS_STATUS, 0);
      chk("rts_low", rd[9], 0);
      chk("status_bits", rd[8:1], 8'b10011000);
      $display("reset and start-up done");
      xfer(1, `SIS_OFS_TXIVL, 32'd16);
      xfer(1, `SIS_OFS_CFG, 32'h00164b00);
      // Indicator levels and periods
      foreach (rows[i]) begin
         {rx, tx, slp, tool, esc} <= rows[i].in;
         ticks(3);
         stat_gap(n);
         stat_gap(n);
         chk("stat_gap", n, rows[i].per);
         if (rows[i].per == 300) chk("stat_lvl", stat, rows[i].lvl);
      end
      $display("indicator table done");
      // Service override with masked then enabled interrupt
      {rx, tx, slp, tool, esc} <= 5'b0;
      svc_cmd <= 1'b1;
      ticks(4);
      chk("svc_port", {baud, d8, par, stop2, cmd_en}, {17'h09600, 5'b10001});
      xfer(0, `SIS_OFS_CFG, 0);
      chk("svc_cfg", rd, 32'h00164b00);
      xfer(0, `SIS_OFS_INTST, 0);
      chk("svc_int", {rd[3], irq}, 2'b10);
      xfer(1, `SIS_OFS_INTEN, 32'h8);
      ticks(3);
      chk("irq_on", irq, 1);
      xfer(1, `SIS_OFS_INTCLR, 32'h8);
      ticks(3);
      chk("irq_clr", irq, 0);
      svc_cmd <= 1'b0;
      ticks(4);
      chk("svc_back", {baud, d8, par, stop2, cmd_en}, {17'h04b00, 5'b10110});
      chk("irq_again", irq, 1);
      xfer(1, `SIS_OFS_INTEN, 32'h0);
      ticks(3);
      chk("irq_mask", irq, 0);
      xfer(1, `SIS_OFS_INTCLR, 32'hf);
      $display("service access done");
      // Fault while the tool link is up
      tool <= 1'b1;
      fault <= 1'b1;
      t0 = cyc;
      ticks(1);
      fault <= 1'b0;
      ticks(3);
      chk("fault_pins", {inhibit, cts_n}, 2'b11);
      stat_gap(n);
      stat_gap(n);
      chk("fault_gap", n, 10);
      xfer(0, `SIS_OFS_FCODE, 0);
      chk("fault_code", rd, 32'ha5);
      n = 0;
      while (reboot !== 1'b1 && n < 400) begin
         ticks(1);
         n++;
      end
      chk("reboot_time", cyc - t0 >= 198 && cyc - t0 <= 206, 1);
      ticks(3);
      chk("inhibit_off", inhibit, 0);
      xfer(0, `SIS_OFS_INTST, 0);
      chk("fault_int", rd[1:0], 2'b11);
      tool <= 1'b0;
      $display("fault and reboot done");
      // Enable pin low clears volatile state only
      ena_cmd <= 1'b0;
      ticks(4);
      chk("off_pins", {stat, cts_n}, 2'b01);
      xfer(0, `SIS_OFS_CFG, 0);
      chk("off_cfg", rd, 32'h00164b00);
      ena_cmd <= 1'b1;
      cts_wait(n);
      chk("cts_again", n >= 30 && n <= 36, 1);
      xfer(1, 8'h40, 32'hffffffff);
      xfer(0, 8'h40, 0);
      chk("unmapped", rd, 32'h0);
      chk("hresp", hresp, 0);
      $display("enable and unmapped done");
      summarize;
   end
endmodule
